// ==== hw/dual_channel_io_port.sv ====
// Two eight-pin general purpose I/O ports with change detection, behind AXI4-Lite.
//
// Our own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "io_port_consts.svh"

module dual_channel_io_port #(
  parameter int PINS = 8
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data.
  input wire logic [`IOP_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address and data.
  input wire logic [`IOP_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Port pins of channel A and B, bit n for pin n.
  input wire logic [PINS-1:0] pin_in_a,
  output logic [PINS-1:0] pin_out_a,
  output logic [PINS-1:0] pin_oe_a,
  input wire logic [PINS-1:0] pin_in_b,
  output logic [PINS-1:0] pin_out_b,
  output logic [PINS-1:0] pin_oe_b,
  // Alternate sources from the UART clocks and counter/timers.
  input wire logic transmit_clock_16x_a,
  input wire logic transmit_clock_1x_a,
  input wire logic receive_clock_16x_a,
  input wire logic receive_clock_16x_b,
  input wire logic receive_clock_1x_b,
  input wire logic receive_clock_1x_a,
  input wire logic counter_timer_0_out,
  input wire logic counter_timer_1_out,
  // Pin levels towards the UART as general inputs and modem or clock inputs.
  output logic [PINS-1:0] general_input_a,
  output logic [PINS-1:0] general_input_b
);

  localparam int NPIN = 2 * PINS;

  // Software-visible state; configuration is one array of four bytes.
  logic [7:0] cfg_reg [4];
  logic [NPIN-1:0] latch_reg;
  logic [NPIN-1:0] chg_en_reg;
  logic [NPIN-1:0] flag_reg;
  logic [NPIN-1:0] level_reg;
  logic [NPIN-1:0] prev_reg;
  logic [NPIN-1:0] drive_next;
  logic [NPIN-1:0] oe_next;
  logic [NPIN-1:0] is_output;
  logic [NPIN-1:0] flag_view;
  logic [NPIN-1:0] flag_clear;
  logic [7:0] alt_src;

  // Bus side state.
  logic [`IOP_ADDR_W-1:0] waddr_reg;
  logic [7:0] wbyte_reg;
  logic wstrb0_reg;
  logic aw_have_reg;
  logic w_have_reg;
  logic do_write;
  logic wr_hit;
  logic rd_hit;
  logic [7:0] rd_byte;
  logic ar_take;

  assign alt_src[`IOP_ALT_TXC16_A] = transmit_clock_16x_a;
  assign alt_src[`IOP_ALT_TXC1_A] = transmit_clock_1x_a;
  assign alt_src[`IOP_ALT_RXC16_A] = receive_clock_16x_a;
  assign alt_src[`IOP_ALT_RXC16_B] = receive_clock_16x_b;
  assign alt_src[`IOP_ALT_RXC1_B] = receive_clock_1x_b;
  assign alt_src[`IOP_ALT_RXC1_A] = receive_clock_1x_a;
  assign alt_src[`IOP_ALT_CT0] = counter_timer_0_out;
  assign alt_src[`IOP_ALT_CT1] = counter_timer_1_out;

  // Pin mux per pin; returns {enable, level}. Pins 0..7 are A, 8..15 are B.
  function automatic logic [1:0] pin_drive(input int idx, input logic [1:0] code,
                                           input logic latch, input logic [7:0] alt);
    logic [1:0] res;
    res = 2'h0;
    case (io_port_pkg::pin_cfg_e'(code))
      io_port_pkg::cfg_input: res = 2'h0;
      io_port_pkg::cfg_latch: res = {1'b1, ~latch};
      io_port_pkg::cfg_alt_clock: begin
        case (idx)
          `IOP_PIN_A3: res = {1'b1, alt[`IOP_ALT_TXC16_A]};
          `IOP_PIN_A2: res = {1'b1, alt[`IOP_ALT_TXC1_A]};
          `IOP_PIN_A4: res = {1'b1, alt[`IOP_ALT_RXC16_A]};
          `IOP_PIN_A6: res = {1'b1, alt[`IOP_ALT_RXC16_B]};
          `IOP_PIN_B3: res = {1'b1, alt[`IOP_ALT_RXC1_B]};
          `IOP_PIN_B2: res = {1'b1, alt[`IOP_ALT_RXC1_A]};
          default: res = 2'h0;
        endcase
      end
      io_port_pkg::cfg_alt_other: begin
        case (idx)
          `IOP_PIN_B3: res = {~alt[`IOP_ALT_CT0], 1'b0};
          `IOP_PIN_B2: res = {~alt[`IOP_ALT_CT1], 1'b0};
          default: res = 2'h0;
        endcase
      end
      default: res = 2'h0;
    endcase
    return res;
  endfunction

  // Per-pin drive, output decode and detector view.
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      logic [1:0] drv;
      logic [1:0] code;
      assign code = cfg_reg[gi / 4][(gi % 4) * 2 +: 2];
      assign drv = pin_drive(gi, code, latch_reg[gi], alt_src);
      assign oe_next[gi] = drv[1];
      assign drive_next[gi] = drv[0];
      // Open-drain pins count as outputs only while they actually pull low.
      assign is_output[gi] = (code == io_port_pkg::cfg_latch) || drv[1];
      assign flag_view[gi] = flag_reg[gi] & chg_en_reg[gi] & ~is_output[gi];
    end
  endgenerate

  // Pins are sampled once; both the levels and the detector use this copy.
  // input always live
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      level_reg <= '0;
      prev_reg <= '0;
    end else begin
      level_reg <= {pin_in_b, pin_in_a};
      prev_reg <= level_reg;
    end
  end

  // Change flags; a new change wins over a read that clears in the same cycle.
  // detector enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= (flag_reg & ~flag_clear) | ((level_reg ^ prev_reg) & chg_en_reg);
    end
  end

  // Drivers come from flops so the pins never glitch through the mux.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_oe_a <= '0;
      pin_oe_b <= '0;
      pin_out_a <= '0;
      pin_out_b <= '0;
      general_input_a <= '0;
      general_input_b <= '0;
    end else begin
      pin_oe_a <= oe_next[PINS-1:0];
      pin_oe_b <= oe_next[NPIN-1:PINS];
      pin_out_a <= drive_next[PINS-1:0];
      pin_out_b <= drive_next[NPIN-1:PINS];
      general_input_a <= level_reg[PINS-1:0];
      general_input_b <= level_reg[NPIN-1:PINS];
    end
  end

  // Write channels are taken independently and joined here.
  assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
  always_comb begin
    case (waddr_reg)
      `IOP_CHG_EN_A, `IOP_LATCH_A, `IOP_CHG_EN_B, `IOP_LATCH_B,
      `IOP_CFG_A_LOW, `IOP_CFG_A_HIGH, `IOP_CFG_B_LOW, `IOP_CFG_B_HIGH: wr_hit = 1'b1;
      // Read-only registers refuse writes as well as unmapped holes.
      default: wr_hit = 1'b0;
    endcase
  end

  // Write address handshake; ready returns only after the response is taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_have_reg <= 1'b0;
      waddr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_have_reg <= 1'b1;
      waddr_reg <= s_axi_awaddr;
    end else if (do_write) begin
      aw_have_reg <= 1'b0;
    end else if (!aw_have_reg && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  // Write data handshake.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_have_reg <= 1'b0;
      wbyte_reg <= `IOP_BYTE_RESET;
      wstrb0_reg <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_have_reg <= 1'b1;
      wbyte_reg <= s_axi_wdata[7:0];
      wstrb0_reg <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_have_reg <= 1'b0;
    end else if (!w_have_reg && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  // Write response.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `IOP_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? `IOP_RESP_OKAY : `IOP_RESP_SLVERR;
    end else if (s_axi_bready && s_axi_bvalid) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Software registers; only byte lane 0 carries data.
  // configuration resets
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int k = 0; k < 4; k++) begin
        cfg_reg[k] <= `IOP_CFG_RESET;
      end
      latch_reg <= '0;
      chg_en_reg <= '0;
    end else if (do_write && wstrb0_reg) begin
      case (waddr_reg)
        `IOP_CHG_EN_A: chg_en_reg[PINS-1:0] <= wbyte_reg;
        `IOP_CHG_EN_B: chg_en_reg[NPIN-1:PINS] <= wbyte_reg;
        `IOP_LATCH_A: latch_reg[PINS-1:0] <= wbyte_reg;
        `IOP_LATCH_B: latch_reg[NPIN-1:PINS] <= wbyte_reg;
        `IOP_CFG_A_LOW: cfg_reg[0] <= wbyte_reg;
        `IOP_CFG_A_HIGH: cfg_reg[1] <= wbyte_reg;
        `IOP_CFG_B_LOW: cfg_reg[2] <= wbyte_reg;
        `IOP_CFG_B_HIGH: cfg_reg[3] <= wbyte_reg;
        default: ;
      endcase
    end
  end

  // Read decode; change registers pair flags above the live levels.
  assign ar_take = s_axi_arvalid && s_axi_arready;
  always_comb begin
    rd_hit = 1'b1;
    rd_byte = `IOP_BYTE_RESET;
    flag_clear = '0;
    case (s_axi_araddr)
      `IOP_LEVELS_A: rd_byte = level_reg[PINS-1:0];
      `IOP_LEVELS_B: rd_byte = level_reg[NPIN-1:PINS];
      `IOP_CHG_LOW_A: begin
        rd_byte = {flag_view[3:0], level_reg[3:0]};
        flag_clear[3:0] = {4{ar_take}};
      end
      `IOP_CHG_LOW_B: begin
        rd_byte = {flag_view[11:8], level_reg[11:8]};
        flag_clear[11:8] = {4{ar_take}};
      end
      `IOP_CHG_HIGH_A: begin
        rd_byte = {flag_view[7:4], level_reg[7:4]};
        flag_clear[7:4] = {4{ar_take}};
      end
      `IOP_CHG_HIGH_B: begin
        rd_byte = {flag_view[15:12], level_reg[15:12]};
        flag_clear[15:12] = {4{ar_take}};
      end
      `IOP_CHG_EN_A: rd_byte = chg_en_reg[PINS-1:0];
      `IOP_CHG_EN_B: rd_byte = chg_en_reg[NPIN-1:PINS];
      `IOP_LATCH_A: rd_byte = latch_reg[PINS-1:0];
      `IOP_LATCH_B: rd_byte = latch_reg[NPIN-1:PINS];
      `IOP_CFG_A_LOW: rd_byte = cfg_reg[0];
      `IOP_CFG_A_HIGH: rd_byte = cfg_reg[1];
      `IOP_CFG_B_LOW: rd_byte = cfg_reg[2];
      `IOP_CFG_B_HIGH: rd_byte = cfg_reg[3];
      default: rd_hit = 1'b0;
    endcase
  end

  // Read channel; data are captured at the address handshake.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `IOP_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rd_byte};
      s_axi_rresp <= rd_hit ? `IOP_RESP_OKAY : `IOP_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule // dual_channel_io_port

// ==== hw/io_port_consts.svh ====
// Register offsets, reset values and bus answer codes of the dual-channel I/O port.
`ifndef IO_PORT_CONSTS_SVH
`define IO_PORT_CONSTS_SVH
`define IOP_ADDR_W 8
`define IOP_LEVELS_A 8'h00
`define IOP_CHG_LOW_A 8'h04
`define IOP_CHG_HIGH_A 8'h08
`define IOP_CHG_EN_A 8'h0C
`define IOP_LATCH_A 8'h10
`define IOP_LEVELS_B 8'h20
`define IOP_CHG_LOW_B 8'h24
`define IOP_CHG_HIGH_B 8'h28
`define IOP_CHG_EN_B 8'h2C
`define IOP_LATCH_B 8'h30
`define IOP_CFG_A_LOW 8'h40
`define IOP_CFG_A_HIGH 8'h44
`define IOP_CFG_B_LOW 8'h48
`define IOP_CFG_B_HIGH 8'h4C
`define IOP_CFG_RESET 8'h00
`define IOP_BYTE_RESET 8'h00
`define IOP_RESP_OKAY 2'h0
`define IOP_RESP_SLVERR 2'h2
`define IOP_ALT_TXC16_A 0
`define IOP_ALT_TXC1_A 1
`define IOP_ALT_RXC16_A 2
`define IOP_ALT_RXC16_B 3
`define IOP_ALT_RXC1_B 4
`define IOP_ALT_RXC1_A 5
`define IOP_ALT_CT0 6
`define IOP_ALT_CT1 7
`define IOP_PIN_A2 2
`define IOP_PIN_A3 3
`define IOP_PIN_A4 4
`define IOP_PIN_A6 6
`define IOP_PIN_B2 10
`define IOP_PIN_B3 11
`endif

// ==== hw/io_port_pkg.sv ====
// Types shared by the dual-channel I/O port.
package io_port_pkg;
  // Two-bit pin configuration codes in their field order.
  typedef enum logic [1:0] {
    cfg_input,
    cfg_latch,
    cfg_alt_clock,
    cfg_alt_other
  } pin_cfg_e;
endpackage

// ==== tb/io_pins_model.sv ====
// Pin model: the outside world seen by the eight pins of one channel.
`timescale 1ns/1ps

module io_pins_model (
  // Block side of the pins.
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  // Outside source, weaker than the block's own driver.
  input wire logic [7:0] ext_level,
  // Resolved level fed back to the block.
  output logic [7:0] pin_level
);
  // The block wins wherever it drives, so no pin ever floats to an unknown.
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // io_pins_model

// ==== tb/io_port_props.sv ====
// Checker of the I/O port's bus answers and pin behaviour at its ports.
`timescale 1ns/1ps
`include "io_port_consts.svh"

module io_port_props #(
  parameter int PINS = 8
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Bus handshakes.
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pins.
  input wire logic [PINS-1:0] pin_in_a,
  input wire logic [PINS-1:0] pin_oe_a,
  input wire logic [PINS-1:0] pin_oe_b,
  input wire logic [PINS-1:0] general_input_a
);
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Answers stand until the master takes them.
  a_bresp_holds: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  a_rdata_holds: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  // Both halves are first held, so the answer shows one edge after the join.
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_byte_wide: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data wider than a byte");
  a_bresp_legal: assert property (
    s_axi_bvalid |-> s_axi_bresp == `IOP_RESP_OKAY || s_axi_bresp == `IOP_RESP_SLVERR)
    else $error("write answer code unknown");
  // Pins are inputs straight after reset.
  a_pins_idle_reset: assert property (
    $rose(aresetn) |-> pin_oe_a == '0 && pin_oe_b == '0)
    else $error("pin driven after reset");
  // The level copy trails the pin by two edges.
  a_level_follows: assert property (
    aresetn && $past(aresetn) && $past(aresetn, 2) |-> general_input_a == $past(pin_in_a, 2))
    else $error("level copy does not follow pin");

  c_write_refused: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == `IOP_RESP_SLVERR);
  c_read_done: cover property (s_axi_rvalid && s_axi_rready);
  c_pin_driven: cover property ($rose(pin_oe_a[3]));
endmodule // io_port_props

bind dual_channel_io_port io_port_props #(.PINS(PINS)) chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .pin_in_a(pin_in_a), .pin_oe_a(pin_oe_a), .pin_oe_b(pin_oe_b),
  .general_input_a(general_input_a)
);

// ==== tb/test_dual_channel_io_port.sv ====
// Self-checking testbench for the dual-channel I/O port.
`timescale 1ns/1ps
`include "io_port_consts.svh"

module test_dual_channel_io_port;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h00000000, rdata;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [7:0] pin_in_a, pin_out_a, pin_oe_a, pin_in_b, pin_out_b, pin_oe_b, gin_a, gin_b;
  logic [7:0] ext_a = 8'h00, ext_b = 8'h00, alt = 8'h00;
  int fail_count = 0, total_checks = 0;

  // Free-running system clock.
  always #20 aclk = ~aclk;

  dual_channel_io_port uut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .pin_in_a(pin_in_a), .pin_out_a(pin_out_a), .pin_oe_a(pin_oe_a), .pin_in_b(pin_in_b),
    .pin_out_b(pin_out_b), .pin_oe_b(pin_oe_b), .transmit_clock_16x_a(alt[0]),
    .transmit_clock_1x_a(alt[1]), .receive_clock_16x_a(alt[2]), .receive_clock_16x_b(alt[3]),
    .receive_clock_1x_b(alt[4]), .receive_clock_1x_a(alt[5]), .counter_timer_0_out(alt[6]),
    .counter_timer_1_out(alt[7]), .general_input_a(gin_a), .general_input_b(gin_b)
  );
  io_pins_model pins_a (
    .pin_out(pin_out_a), .pin_oe(pin_oe_a), .ext_level(ext_a), .pin_level(pin_in_a)
  );
  io_pins_model pins_b (
    .pin_out(pin_out_b), .pin_oe(pin_oe_b), .ext_level(ext_b), .pin_level(pin_in_b)
  );

  // Compares one value and counts it.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Ends the run with the verdict.
  task automatic finish_test();
    if (fail_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One write; address and data are released as each is taken; only the watchdog ends a wait.
  task automatic bus_write(input logic [7:0] addr, input logic [7:0] data,
                           output logic [1:0] resp);
    @(posedge aclk);
    awaddr <= addr;
    wdata <= {24'h000000, data};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    resp = bresp;
  endtask

  // One read; the answer is taken at the edge where it is seen.
  task automatic bus_read(input logic [7:0] addr, output logic [31:0] data,
                          output logic [1:0] resp);
    @(posedge aclk);
    araddr <= addr;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    data = rdata;
    resp = rresp;
  endtask

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    logic [1:0] r;
    bus_write(addr, data, r);
    check("bresp", {30'h0, r}, 32'h0);
  endtask

  task automatic rd(input string what, input logic [7:0] addr, input logic [7:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    bus_read(addr, d, r);
    // Data and answer code are judged apart so that neither can hide the other.
    check(what, d, {24'h000000, exp});
    check("rresp", {30'h0, r}, 32'h0);
  endtask

  task automatic t_reset();
    rd("cfg_a_low", `IOP_CFG_A_LOW, 8'h00);
    rd("cfg_a_high", `IOP_CFG_A_HIGH, 8'h00);
    rd("cfg_b_low", `IOP_CFG_B_LOW, 8'h00);
    check("oe_reset", {16'h0, pin_oe_a, pin_oe_b}, 32'h0);
  endtask

  // levels seen, flags masked while disabled.
  task automatic t_levels();
    ext_a <= 8'hA5;
    ext_b <= 8'h3C;
    repeat (4) @(posedge aclk);
    rd("levels_a", `IOP_LEVELS_A, 8'hA5);
    rd("levels_b", `IOP_LEVELS_B, 8'h3C);
    rd("low_a", `IOP_CHG_LOW_A, 8'h05);
    rd("high_a", `IOP_CHG_HIGH_A, 8'h0A);
    check("gin", {16'h0, gin_a, gin_b}, 32'hA53C);
  endtask

  // per-pin enables gate the change flags.
  task automatic t_change();
    wr(`IOP_CHG_EN_A, 8'h0F);
    wr(`IOP_CHG_EN_B, 8'hFF);
    ext_a <= 8'h5A;
    ext_b <= 8'hC3;
    repeat (4) @(posedge aclk);
    rd("low_a_flags", `IOP_CHG_LOW_A, 8'hFA);
    rd("high_a_off", `IOP_CHG_HIGH_A, 8'h05);
    rd("low_a_clear", `IOP_CHG_LOW_A, 8'h0A);
    rd("high_b_flags", `IOP_CHG_HIGH_B, 8'hFC);
  endtask

  // latch drives inverted levels, inputs still read, output flags hidden.
  task automatic t_latch();
    wr(`IOP_LATCH_A, 8'h3A);
    wr(`IOP_CFG_A_LOW, 8'h55);
    wr(`IOP_CFG_A_HIGH, 8'h55);
    repeat (2) @(posedge aclk);
    check("oe_a", {24'h0, pin_oe_a}, 32'hFF);
    check("out_a", {24'h0, pin_out_a}, 32'hC5);
    repeat (3) @(posedge aclk);
    rd("levels_drv", `IOP_LEVELS_A, 8'hC5);
    // The low pins turned from A to 5 while driving, so their set flags must stay hidden.
    rd("low_out", `IOP_CHG_LOW_A, 8'h05);
  endtask

  // each clock output follows its own source only.
  task automatic t_clocks();
    logic [7:0] addr_t [6] = '{`IOP_CFG_A_LOW, `IOP_CFG_A_LOW, `IOP_CFG_A_HIGH, `IOP_CFG_A_HIGH,
                               `IOP_CFG_B_LOW, `IOP_CFG_B_LOW};
    logic [7:0] val_t [6] = '{8'h80, 8'h20, 8'h02, 8'h20, 8'h80, 8'h20};
    int pin_t [6] = '{3, 2, 4, 6, 11, 10};
    logic [15:0] oe, out;
    for (int i = 0; i < 6; i++) begin
      wr(addr_t[i], val_t[i]);
      for (int v = 0; v < 2; v++) begin
        alt <= v[0] ? (8'h01 << i) : ~(8'h01 << i);
        repeat (3) @(posedge aclk);
        oe = {pin_oe_b, pin_oe_a};
        out = {pin_out_b, pin_out_a};
        check("alt_pin", {30'h0, oe[pin_t[i]], out[pin_t[i]]}, {30'h0, 1'b1, v[0]});
      end
    end
  endtask

  // open-drain timer outputs; a reserved code stays undriven.
  task automatic t_open_drain();
    wr(`IOP_CFG_B_LOW, 8'hF2);
    alt <= 8'h00;
    repeat (3) @(posedge aclk);
    check("od_pull", {28'h0, pin_oe_b[3], pin_out_b[3], pin_oe_b[2], pin_out_b[2]}, 32'hA);
    // software keeps to legal codes elsewhere; this one probe shows the safe fallback.
    check("reserved", {31'h0, pin_oe_b[0]}, 32'h0);
    alt <= 8'h40;
    repeat (3) @(posedge aclk);
    check("od_free", {30'h0, pin_oe_b[3], pin_oe_b[2]}, 32'h1);
  endtask

  // read-only and unmapped places refuse writes.
  task automatic t_refuse();
    logic [1:0] r;
    logic [31:0] d;
    bus_write(8'hFC, 8'h11, r);
    check("unmapped_w", {30'h0, r}, {30'h0, `IOP_RESP_SLVERR});
    bus_write(`IOP_LEVELS_A, 8'h11, r);
    check("ro_w", {30'h0, r}, {30'h0, `IOP_RESP_SLVERR});
    bus_read(8'hFC, d, r);
    check("unmapped_r", d | {30'h0, r}, {30'h0, `IOP_RESP_SLVERR});
    // A write with byte lane 0 off is answered but changes nothing.
    wstrb <= 4'h0;
    bus_write(`IOP_LATCH_B, 8'hFF, r);
    wstrb <= 4'hF;
    check("strobe_off_w", {30'h0, r}, 32'h0);
    rd("strobe_off", `IOP_LATCH_B, 8'h00);
  endtask

  // Main sequence after a two-cycle reset.
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_levels();
    t_change();
    t_latch();
    t_clocks();
    t_open_drain();
    t_refuse();
    // a reset in mid-run must undo the configuration written above.
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    finish_test();
  end

  // Watchdog: the whole sequence needs well under this span.
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    finish_test();
  end
endmodule // test_dual_channel_io_port
